// file: verilog/acs_params.svh
// constants for the conversion sequencer: field codes, resets, timing
// assumes inclusion by bare name from the sequencer sources
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ==========================================================
// multiplexer field codes
`define ACS_MUX_D01      3'h0
`define ACS_MUX_D03      3'h1
`define ACS_MUX_D13      3'h2
`define ACS_MUX_D23      3'h3
`define ACS_MUX_S0       3'h4
`define ACS_MUX_S1       3'h5
`define ACS_MUX_S2       3'h6
`define ACS_MUX_S3       3'h7

// ==========================================================
// gain field codes (codes 5..7 also give the narrowest range)
`define ACS_GAIN_2_3     3'h0
`define ACS_GAIN_1       3'h1
`define ACS_GAIN_2       3'h2
`define ACS_GAIN_4       3'h3
`define ACS_GAIN_8       3'h4
`define ACS_GAIN_16      3'h5

// ==========================================================
// full-scale ranges in millivolts
`define ACS_FS_6144      16'h1800
`define ACS_FS_4096      16'h1000
`define ACS_FS_2048      16'h0800
`define ACS_FS_1024      16'h0400
`define ACS_FS_512       16'h0200
`define ACS_FS_256       16'h0100

// ==========================================================
// reset values of configuration
`define ACS_RST_MUX      3'h0
`define ACS_RST_GAIN     3'h2
`define ACS_RST_CONT     1'b0
`define ACS_RST_RATE     3'h4

// ==========================================================
// result codes
`define ACS_CODE_MAX     16'h7fff
`define ACS_CODE_MIN     16'h8000
`define ACS_CODE_ZERO    16'h0000

// ==========================================================
// timing: mclk rate and samples per second per data rate code
`define ACS_MCLK_HZ      10000000
`define ACS_SPS_0        8
`define ACS_SPS_1        16
`define ACS_SPS_2        32
`define ACS_SPS_3        64
`define ACS_SPS_4        128
`define ACS_SPS_5        250
`define ACS_SPS_6        475
`define ACS_SPS_7        860

`endif

// file: verilog/acs_pkg.sv
// types for the conversion sequencer
// assumes nothing of its surroundings
`default_nettype none

package acs_pkg;
  // sequencer states
  typedef enum logic [1:0]
  {
    ACS_ST_OFF  = 2'b00,
    ACS_ST_CONV = 2'b01,
    ACS_ST_DONE = 2'b10
  } acs_state_e;

  typedef logic [15:0] acs_code_t;
endpackage

`default_nettype wire

// file: verilog/acs_scale.sv
// scaling of one raw sample into a saturated 16-bit result
// assumes raw sample is a signed millivolt level from the modulator model
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"

module acs_scale
(
  input  wire logic [2:0]  gain_stage_setting, // gain code
  input  wire logic        single_ended,       // negative side grounded
  input  wire logic [17:0] sample_mv,          // signed input level, mV
  output logic      [15:0] result_code         // scaled result
);

  // ==========================================================
  // full-scale lookup
  function automatic logic [15:0] acs_fs(input logic [2:0] g);
    case (g)
      `ACS_GAIN_2_3: acs_fs = `ACS_FS_6144;
      `ACS_GAIN_1:   acs_fs = `ACS_FS_4096;
      `ACS_GAIN_2:   acs_fs = `ACS_FS_2048;
      `ACS_GAIN_4:   acs_fs = `ACS_FS_1024;
      `ACS_GAIN_8:   acs_fs = `ACS_FS_512;
      default:       acs_fs = `ACS_FS_256;
    endcase
  endfunction

  wire logic [15:0] fs_mv = acs_fs(gain_stage_setting);
  wire logic        neg   = sample_mv[17];
  wire logic [17:0] mag   = neg ? (~sample_mv + 18'h00001) : sample_mv;
  // code = mag * 32768 / fs
  wire logic [33:0] prod  = {1'b0, mag, 15'h0000};
  wire logic [33:0] quo   = prod / {18'h00000, fs_mv};
  wire logic        over_p = (quo > 34'h000007fff);
  wire logic        over_n = (quo > 34'h000008000);
  wire logic [15:0] qlo   = quo[15:0];
  wire logic [15:0] negq  = ~qlo + 16'h0001;

  // ==========================================================
  // saturation and single-ended clamp
  assign result_code = (neg && single_ended) ? `ACS_CODE_ZERO :
                       (neg && over_n)       ? `ACS_CODE_MIN :
                       neg                   ? negq :
                       over_p                ? `ACS_CODE_MAX :
                                               qlo;

endmodule

`default_nettype wire

// file: verilog/acs_sequencer.sv
// conversion sequencer: mode control, input select, result register
// assumes analog levels arrive as signed mV words from outside the domain
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"

// Notes on behaviour
// - single-shot: one conversion per host request
// - single-shot: shut down after the conversion
// - continuous: next conversion starts at once
// - continuous result rate equals programmed rate
// - result register always holds latest conversion
// - three-bit field selects the input pair
// - inputs zero, one and two against input three
// - single-ended ties negative input to ground
// - single-ended results never negative
// - three-bit gain field, two-thirds to sixteen
// - each gain maps to one full-scale range
// - two's complement, saturating at full scale
// - single-shot: start bit clears while busy, sets when done
// - start write while converting is ignored
// - after reset powered down until configured
module acs_sequencer
(
  input  wire logic        mclk,                  // 10 MHz clock
  input  wire logic        reset_n,               // sync reset, low
  input  wire logic        config_write,          // config write strobe
  input  wire logic [2:0]  mux_select,            // input pair field
  input  wire logic [2:0]  gain_stage_setting,    // gain field
  input  wire logic        continuous_mode,       // 1 continuous
  input  wire logic [2:0]  data_rate,             // rate code
  input  wire logic        start_write,           // start bit written 1
  input  wire logic [17:0] analog_input_zero,     // signed mV
  input  wire logic [17:0] analog_input_one,      // signed mV
  input  wire logic [17:0] analog_input_two,      // signed mV
  input  wire logic [17:0] analog_input_three,    // signed mV
  output logic             single_shot_start_status, // 1 idle/ready
  output logic      [15:0] conversion_result,     // latest result
  output logic             result_strobe,         // one-cycle new result
  output logic             powered_down,          // shutdown state
  output logic             ground_switch_closed,  // negative to ground
  output logic      [2:0]  positive_converter_input, // selected positive
  output logic      [2:0]  negative_converter_input, // selected negative
  output logic      [2:0]  active_gain,           // gain in use
  output logic      [2:0]  active_mux             // mux in use
);

  // ==========================================================
  // cycles per conversion for each rate code
  localparam int unsigned CYC0 = `ACS_MCLK_HZ / `ACS_SPS_0;
  localparam int unsigned CYC1 = `ACS_MCLK_HZ / `ACS_SPS_1;
  localparam int unsigned CYC2 = `ACS_MCLK_HZ / `ACS_SPS_2;
  localparam int unsigned CYC3 = `ACS_MCLK_HZ / `ACS_SPS_3;
  localparam int unsigned CYC4 = `ACS_MCLK_HZ / `ACS_SPS_4;
  localparam int unsigned CYC5 = `ACS_MCLK_HZ / `ACS_SPS_5;
  localparam int unsigned CYC6 = `ACS_MCLK_HZ / `ACS_SPS_6;
  localparam int unsigned CYC7 = `ACS_MCLK_HZ / `ACS_SPS_7;

  // conversion length in cycles from a rate code
  function automatic logic [20:0] acs_len(input logic [2:0] r);
    case (r)
      3'h0:    acs_len = 21'(CYC0);
      3'h1:    acs_len = 21'(CYC1);
      3'h2:    acs_len = 21'(CYC2);
      3'h3:    acs_len = 21'(CYC3);
      3'h4:    acs_len = 21'(CYC4);
      3'h5:    acs_len = 21'(CYC5);
      3'h6:    acs_len = 21'(CYC6);
      default: acs_len = 21'(CYC7);
    endcase
  endfunction

  // ==========================================================
  // analog word synchronisers (two flops each)
  logic [17:0] ain_s1_ff [4];  // first stage
  logic [17:0] ain_s2_ff [4];  // second stage, only one read

  always_ff @(posedge mclk)
  begin
    ain_s1_ff[0] <= analog_input_zero;
    ain_s1_ff[1] <= analog_input_one;
    ain_s1_ff[2] <= analog_input_two;
    ain_s1_ff[3] <= analog_input_three;
    ain_s2_ff    <= ain_s1_ff;
  end

  // ==========================================================
  // configuration registers
  logic [2:0] mux_ff;    // mux setting
  logic [2:0] gain_ff;   // gain setting
  logic       cont_ff;   // continuous mode
  logic [2:0] rate_ff;   // rate code
  logic       cfgd_ff;   // written since reset

  // load defaults at reset, take writes afterwards
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      mux_ff  <= `ACS_RST_MUX;
      gain_ff <= `ACS_RST_GAIN;
      cont_ff <= `ACS_RST_CONT;
      rate_ff <= `ACS_RST_RATE;
      cfgd_ff <= 1'b0;
    end
    else if (config_write)
    begin
      mux_ff  <= mux_select;
      gain_ff <= gain_stage_setting;
      cont_ff <= continuous_mode;
      rate_ff <= data_rate;
      cfgd_ff <= 1'b1;
    end
  end

  // ==========================================================
  // multiplexer decode
  wire logic se = mux_ff[2];                          // single-ended codes
  wire logic [2:0] pos_sel =
    se                       ? {1'b0, mux_ff[1:0]} :
    (mux_ff == `ACS_MUX_D23) ? 3'h2 :
    (mux_ff == `ACS_MUX_D13) ? 3'h1 : 3'h0;
  // code 4 means ground on the negative side
  wire logic [2:0] neg_sel =
    se                       ? 3'h4 :
    (mux_ff == `ACS_MUX_D01) ? 3'h1 : 3'h3;

  function automatic logic [17:0] acs_pick(input logic [2:0] s,
                                           input logic [17:0] a0,
                                           input logic [17:0] a1,
                                           input logic [17:0] a2,
                                           input logic [17:0] a3);
    case (s)
      3'h0:    acs_pick = a0;
      3'h1:    acs_pick = a1;
      3'h2:    acs_pick = a2;
      3'h3:    acs_pick = a3;
      default: acs_pick = 18'h00000;
    endcase
  endfunction

  wire logic [17:0] vp = acs_pick(pos_sel, ain_s2_ff[0], ain_s2_ff[1],
                                  ain_s2_ff[2], ain_s2_ff[3]);
  wire logic [17:0] vn = acs_pick(neg_sel, ain_s2_ff[0], ain_s2_ff[1],
                                  ain_s2_ff[2], ain_s2_ff[3]);
  wire logic [17:0] vdiff = vp - vn;
  wire logic [15:0] scaled;

  acs_scale u_scale
  (
    .gain_stage_setting (gain_ff),
    .single_ended       (se),
    .sample_mv          (vdiff),
    .result_code        (scaled)
  );

  // ==========================================================
  // sequencer state
  acs_pkg::acs_state_e state_ff;
  acs_pkg::acs_state_e nxt_state;
  logic [20:0]         cnt_ff;     // cycles left in conversion
  logic [20:0]         nxt_cnt;
  acs_pkg::acs_code_t  result_ff;  // conversion register
  logic                ss_ff;      // start/status bit
  logic                strobe_ff;  // result strobe

  wire logic last    = (cnt_ff == 21'h000001);
  wire logic go_ss   = start_write && !cont_ff && cfgd_ff;
  wire logic go_cont = cont_ff && cfgd_ff;

  // next state
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      acs_pkg::ACS_ST_OFF:
      begin
        if (go_ss || go_cont)
        begin
          nxt_state = acs_pkg::ACS_ST_CONV;
          nxt_cnt   = acs_len(rate_ff);
        end
      end
      acs_pkg::ACS_ST_CONV:
      begin
        // start writes here have no effect
        if (last)
        begin
          if (cont_ff)
            nxt_cnt = acs_len(rate_ff);
          else
            nxt_state = acs_pkg::ACS_ST_DONE;
        end
        else
          nxt_cnt = cnt_ff - 21'h000001;
      end
      acs_pkg::ACS_ST_DONE:
      begin
        // single-shot done: shut down until next request
        nxt_state = acs_pkg::ACS_ST_OFF;
      end
      default:
        nxt_state = acs_pkg::ACS_ST_OFF;
    endcase
  end

  wire logic finish = (state_ff == acs_pkg::ACS_ST_CONV) && last;
  wire logic begin_conv = (state_ff == acs_pkg::ACS_ST_OFF) &&
                          (nxt_state == acs_pkg::ACS_ST_CONV);

  // state registers
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state_ff <= acs_pkg::ACS_ST_OFF;
      cnt_ff   <= 21'h000000;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // result register, loaded whole in one edge
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      result_ff <= `ACS_CODE_ZERO;
    else if (finish)
      result_ff <= scaled;
  end

  // start/status bit and strobe
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ss_ff     <= 1'b1;
      strobe_ff <= 1'b0;
    end
    else
    begin
      strobe_ff <= finish;
      if (finish && !cont_ff)
        ss_ff <= 1'b1;
      else if (begin_conv && !cont_ff)
        ss_ff <= 1'b0;
    end
  end

  // ==========================================================
  // outputs
  assign single_shot_start_status = ss_ff;
  assign conversion_result        = result_ff;
  assign result_strobe            = strobe_ff;
  assign powered_down             = (state_ff != acs_pkg::ACS_ST_CONV);
  assign ground_switch_closed     = se;
  assign positive_converter_input = pos_sel;
  assign negative_converter_input = neg_sel;
  assign active_gain              = gain_ff;
  assign active_mux               = mux_ff;

  // ==========================================================
  // checks
  single_done_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (finish && !cont_ff) |=> powered_down && ss_ff)
    else $error("single-shot did not shut down");

  status_clr_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (begin_conv && !cont_ff) |=> !ss_ff)
    else $error("start bit not cleared");

  cont_next_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (finish && cont_ff) |=> !powered_down)
    else $error("continuous conversion stalled");

  result_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !$past(finish) |-> $stable(result_ff))
    else $error("result changed outside a finish");

  result_load_a: assert property (@(posedge mclk) disable iff (!reset_n)
    finish |=> result_ff == $past(scaled))
    else $error("result not loaded whole");

  no_restart_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_ff == acs_pkg::ACS_ST_CONV && !last) |=>
      cnt_ff == $past(cnt_ff) - 21'h000001)
    else $error("conversion restarted early");

  idle_reset_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !cfgd_ff |-> powered_down)
    else $error("conversion before configuration");

  gnd_switch_a: assert property (@(posedge mclk) disable iff (!reset_n)
    se |-> ground_switch_closed && vn == 18'h00000)
    else $error("ground switch open for single-ended");

  se_sign_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (finish && se) |=> !result_ff[15])
    else $error("negative single-ended code");

  rate_len_a: assert property (@(posedge mclk) disable iff (!reset_n)
    begin_conv |=> cnt_ff == acs_len($past(rate_ff)))
    else $error("conversion length wrong");

endmodule

`default_nettype wire

// file: testbench/acs_host_model.sv
// host model: writes configuration, requests conversions, sets levels
// assumes the bench calls its tasks and shares mclk with the sequencer
`timescale 1ns/1ps
`default_nettype none

module acs_host_model
(
  input  wire logic        mclk,               // shared clock
  output logic             config_write,       // config strobe
  output logic      [2:0]  mux_select,         // input pair field
  output logic      [2:0]  gain_stage_setting, // gain field
  output logic             continuous_mode,    // 1 continuous
  output logic      [2:0]  data_rate,          // rate code
  output logic             start_write,        // start request
  output logic      [17:0] analog_input_zero,  // level, mV
  output logic      [17:0] analog_input_one,   // level, mV
  output logic      [17:0] analog_input_two,   // level, mV
  output logic      [17:0] analog_input_three  // level, mV
);
  // ==========================================================
  // quiet values from time zero
  initial
  begin
    {config_write, start_write, continuous_mode} = 3'h0;
    {mux_select, gain_stage_setting, data_rate} = 9'h0;
    {analog_input_zero, analog_input_one} = 36'h0;
    {analog_input_two, analog_input_three} = 36'h0;
  end

  // ==========================================================
  // one-cycle configuration write, fastest rate unless asked otherwise
  task automatic configure(input logic [2:0] m, input logic [2:0] g,
                           input logic c, input logic [2:0] rt = 3'h7);
    @(posedge mclk);
    config_write <= 1'b1;
    mux_select <= m;
    gain_stage_setting <= g;
    continuous_mode <= c;
    data_rate <= rt;
    @(posedge mclk);
    config_write <= 1'b0;
  endtask

  // one-cycle write of one to the start bit
  task automatic start();
    @(posedge mclk);
    start_write <= 1'b1;
    @(posedge mclk);
    start_write <= 1'b0;
  endtask

  // input levels in signed millivolts
  task automatic levels(input int l0, input int l1, input int l2,
                        input int l3);
    @(posedge mclk);
    analog_input_zero <= 18'(l0);
    analog_input_one <= 18'(l1);
    analog_input_two <= 18'(l2);
    analog_input_three <= 18'(l3);
  endtask
endmodule

`default_nettype wire

// file: testbench/tb_top.sv
// bench for the conversion sequencer: host model, result queue, timeout
// assumes 10 MHz mclk; rate codes 7 and 6 (11627, 21052 cycles)
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ==========================================================
  // signals and bookkeeping
  logic                mclk;            // bench clock
  logic                reset_n;         // sync reset
  wire logic           cw, cont, sw;    // host controls
  wire logic [2:0]     mux, gain, rate; // host fields
  wire logic [17:0]    a0, a1, a2, a3;  // levels
  logic                status, strobe, pdn, gsw; // sequencer flags
  logic [15:0]         result;          // latest result
  logic [2:0]          pos, neg, again, amux; // steering, config
  int                  miscompares = 0; // mismatches
  int                  samples_checked = 0; // comparisons
  int                  cyc = 0;         // cycle count
  int                  n_strobe = 0;    // results seen
  int                  strobe_cyc = 0;  // cycle of last result
  int                  r;               // random level
  int                  c1;              // first continuous result
  logic [2:0]          g;               // random gain
  acs_pkg::acs_code_t  exp_q[$];        // expected results
  acs_pkg::acs_code_t  last_exp = 16'h0; // last expectation
  localparam int       N = 11627;       // cycles a conversion
  localparam logic [2:0] POS_T [8] = '{3'h0, 3'h0, 3'h1, 3'h2,
                                       3'h0, 3'h1, 3'h2, 3'h3};
  localparam logic [2:0] NEG_T [8] = '{3'h1, 3'h3, 3'h3, 3'h3,
                                       3'h4, 3'h4, 3'h4, 3'h4};

  acs_host_model host
  (
    .mclk               (mclk),
    .config_write       (cw),
    .mux_select         (mux),
    .gain_stage_setting (gain),
    .continuous_mode    (cont),
    .data_rate          (rate),
    .start_write        (sw),
    .analog_input_zero  (a0),
    .analog_input_one   (a1),
    .analog_input_two   (a2),
    .analog_input_three (a3)
  );

  acs_sequencer uut
  (
    .mclk                     (mclk),
    .reset_n                  (reset_n),
    .config_write             (cw),
    .mux_select               (mux),
    .gain_stage_setting       (gain),
    .continuous_mode          (cont),
    .data_rate                (rate),
    .start_write              (sw),
    .analog_input_zero        (a0),
    .analog_input_one         (a1),
    .analog_input_two         (a2),
    .analog_input_three       (a3),
    .single_shot_start_status (status),
    .conversion_result        (result),
    .result_strobe            (strobe),
    .powered_down             (pdn),
    .ground_switch_closed     (gsw),
    .positive_converter_input (pos),
    .negative_converter_input (neg),
    .active_gain              (again),
    .active_mux               (amux)
  );

  // ==========================================================
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // compare one value, count it, report a mismatch
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask

  // expected code: scaled magnitude, saturated at both ends
  function automatic acs_pkg::acs_code_t code_of(input int mv,
                                                 input logic [2:0] gn);
    int fs;
    int m;
    case (gn)
      3'h0: fs = 6144;
      3'h1: fs = 4096;
      3'h2: fs = 2048;
      3'h3: fs = 1024;
      3'h4: fs = 512;
      default: fs = 256;
    endcase
    m = (mv < 0 ? -mv : mv) * 32768 / fs;
    if (mv >= 0)
      return (m > 32767) ? 16'h7fff : 16'(m);
    return (m >= 32768) ? 16'h8000 : 16'(-m);
  endfunction

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // cycle count and hang limit
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: run timed out", $time);
      summarize();
    end
  end

  // result watcher: oldest note against each new result
  always @(posedge mclk)
  begin
    #1;
    if (strobe === 1'b1)
    begin
      if (exp_q.size() > 0)
        last_exp = exp_q.pop_front();
      else
      begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: result with no note", $time);
      end
      n_strobe = n_strobe + 1;
      strobe_cyc = cyc;
      chk(result, last_exp, "result");
    end
  end

  // bounded wait for the next result
  task automatic wait_strobe();
    int n0;
    n0 = n_strobe;
    for (int k = 0; k < 22000 && n_strobe == n0; k++)
      @(posedge mclk);
    #2;
    if (n_strobe == n0)
    begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: no result in time", $time);
    end
  endtask

  // one single-shot conversion with a refused second start inside it
  task automatic convert(input logic [2:0] m, input logic [2:0] gn,
                         input acs_pkg::acs_code_t e,
                         input logic [2:0] rt = 3'h7, input int len = N);
    int t0;
    int n0;
    host.configure(m, gn, 1'b0, rt);
    repeat (3) @(posedge mclk);
    exp_q.push_back(e);
    host.start();
    #1;
    t0 = cyc;
    chk({14'h0, pdn, status}, 16'h0, "busy flags");
    repeat (100) @(posedge mclk);
    host.start();
    wait_strobe();
    chk({15'h0, strobe_cyc - t0 >= len - 1 && strobe_cyc - t0 <= len + 2},
        16'h1, "length");
    n0 = n_strobe;
    chk({14'h0, pdn, status}, 16'h3, "shutdown");
    repeat (300) @(posedge mclk);
    #1;
    chk({15'h0, n_strobe == n0}, 16'h1, "one result");
    chk(result, e, "held result");
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(32'h9c2157db));
    reset_n = 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk({14'h0, status, pdn}, 16'h3, "reset flags");
    chk({10'h0, again, amux}, 16'h10, "reset config");
    chk(result, 16'h0, "reset result");
    host.start();
    repeat (20) @(posedge mclk);
    #1;
    chk({14'h0, pdn, n_strobe == 0}, 16'h3, "unconfigured");
    $display("test reset done");
    for (int m = 0; m < 8; m++)
    begin
      host.configure(3'(m), 3'(m), 1'b0);
      #1;
      chk({6'h0, gsw, pos, neg, again}, {6'h0, m > 3, POS_T[m], NEG_T[m],
          3'(m)}, "steering");
      chk({13'h0, amux}, {13'h0, 3'(m)}, "mux in use");
    end
    $display("test steering done");
    r = $urandom % 4000;
    g = 3'($urandom % 8);
    host.levels(r, -500, 0, r + 5000);
    convert(3'h4, g, code_of(r, g));
    convert(3'h5, 3'h2, 16'h0, 3'h6, 21052);
    convert(3'h0, 3'h5, 16'h7fff);
    convert(3'h1, 3'h1, 16'h8000);
    $display("test single shot done");
    exp_q.push_back(code_of(-(r + 5000), 3'h0));
    exp_q.push_back(code_of(-(r + 5000), 3'h0));
    host.configure(3'h3, 3'h0, 1'b1);
    wait_strobe();
    c1 = strobe_cyc;
    wait_strobe();
    chk(16'(strobe_cyc - c1), 16'(N), "spacing");
    host.configure(3'h3, 3'h0, 1'b0);
    chk(16'(exp_q.size()), 16'h0, "results left");
    $display("test continuous done");
    summarize();
  end
endmodule

`default_nettype wire
